// ---- core/mmci_detect_test.sv ----
/*
  Detection self-test engine: forces inverted values into the comparators,
  checks every one flags, then reads one storage word.
  Assumes start is a one-cycle pulse and array_valid answers array_read.
*/
module mmci_detect_test (
  input wire logic clk,
  input wire logic rst,
  mmci_test_if.engine tif
);
  typedef enum logic [1:0] {
    TS_IDLE = 2'h0,
    TS_FORCE = 2'h1,
    TS_READ = 2'h2
  } mmci_test_state_type;

  mmci_test_state_type state;
  logic [2:0] settle;
  logic compare_bad;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= TS_IDLE;
      settle <= 3'h0;
      compare_bad <= 1'b0;
      tif.force_compare <= 1'b0;
      tif.array_read <= 1'b0;
      tif.done <= 1'b0;
      tif.fail <= 1'b0;
      tif.low_word <= 16'h0000;
    end else begin
      tif.done <= 1'b0;
      tif.array_read <= 1'b0;
      unique case (state)
        TS_IDLE: begin
          if (tif.start) begin
            state <= TS_FORCE;
            settle <= 3'(mmci_pkg::COMPARE_SETTLE_CYC);
            compare_bad <= 1'b0;
            tif.force_compare <= 1'b1;
          end
        end
        TS_FORCE: begin
          if (settle == 3'h1) begin
            // every comparator must see the complement as a mismatch
            compare_bad <= ~(&tif.compare_flags) | tif.buffer_fail;
            tif.force_compare <= 1'b0;
            tif.array_read <= 1'b1;
            state <= TS_READ;
          end else begin
            settle <= settle - 3'h1;
          end
        end
        TS_READ: begin
          if (tif.array_valid) begin
            tif.low_word <= tif.array_data[15:0];
            tif.fail <= compare_bad;
            tif.done <= 1'b1;
            state <= TS_IDLE;
          end
        end
        default: state <= TS_IDLE;
      endcase
    end
  end
endmodule // mmci_detect_test

// ---- core/mmci_top.sv ----
/*
  Maintenance command decoder and power-up parameter capture of the memory
  control unit.
  Assumes commands arrive one per ICN_VALID_IN pulse while ICN_READY_OUT is
  high, and that the report-line and bus-switch logic answer with done pulses.
*/
module mmci_top (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic ICN_VALID_IN,
  input wire logic ICN_WRITE_IN,
  input wire logic [4:0] ICN_REG_IN,
  input wire logic [15:0] ICN_DATA_IN,
  output logic ICN_READY_OUT,
  output logic REPLY_VALID_OUT,
  output mmci_pkg::mmci_reply_type REPLY_KIND_OUT,
  output logic [15:0] REPLY_DATA_OUT,
  output logic [1:0] REPLY_PARITY_OUT,
  output logic REPORT_VALID_OUT,
  output mmci_pkg::mmci_report_type REPORT_CODE_OUT,
  output logic REPORT_MODULE_LINE_OUT,
  output logic REPORT_BUS_LINE_OUT,
  output logic REPORT_CHECKER_OUT,
  input wire logic REPORT_DONE_IN,
  input wire logic REPORT_RECEIVED_IN,
  input wire mmci_pkg::mmci_report_type REPORT_RECEIVED_CODE_IN,
  output logic CLEAR_REPORT_COUNTER_OUT,
  output logic SWITCH_REQ_OUT,
  output mmci_pkg::mmci_switch_type SWITCH_KIND_OUT,
  input wire logic SWITCH_DONE_IN,
  input wire logic BACKUP_PRESENT_IN,
  input wire logic MEM_REQ_IN,
  output logic MEM_ACCEPT_OUT,
  output logic MEM_REFUSE_OUT,
  output logic ARRAY_READ_OUT,
  output logic [19:0] ARRAY_ADDR_OUT,
  input wire logic [31:0] ARRAY_DATA_IN,
  input wire logic ARRAY_VALID_IN,
  output logic FORCE_COMPARE_OUT,
  input wire logic [mmci_pkg::COMPARE_GROUPS-1:0] COMPARE_FLAGS_IN,
  input wire logic BUFFER_CHECK_FAIL_IN,
  input wire logic INIT_MEM_STROBE_IN,
  input wire logic INIT_PHASE1_STROBE_IN,
  input wire logic INIT_PHASE2_STROBE_IN,
  input wire logic [15:0] MEMORY_BUS_DATA_IN,
  input wire logic [19:0] STORAGE_SIDE_LINES_IN,
  output logic BUS_DETACHED_OUT,
  output logic ON_BACKUP_OUT
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TEST = 3'h1,
    ST_SWITCH = 3'h2,
    ST_REPORT = 3'h3,
    ST_REPORT_WAIT = 3'h4
  } mmci_state_type;
  mmci_state_type state;
  mmci_pkg::mmci_switch_type pend_switch;
  mmci_pkg::mmci_report_type pend_report;
  logic pend_checker;
  logic pend_both_lines;
  logic [15:0] device_type;
  logic [15:0] device_id;
  logic warm_start;
  logic [15:0] array_low;
  logic [15:0] array_high;
  logic [5:0] array_size;
  logic detached;
  logic on_backup;
  logic take;
  logic is_read;
  logic is_write;
  logic [15:0] read_word;
  mmci_test_if tif();

  mmci_detect_test u_detect_test (
    .clk(CLK_IN),
    .rst(RST_IN),
    .tif(tif)
  );

  assign tif.addr = {array_high[3:0], array_low};
  assign tif.array_data = ARRAY_DATA_IN;
  assign tif.array_valid = ARRAY_VALID_IN;
  assign tif.compare_flags = COMPARE_FLAGS_IN;
  assign tif.buffer_fail = BUFFER_CHECK_FAIL_IN;
  assign ARRAY_READ_OUT = tif.array_read;
  assign FORCE_COMPARE_OUT = tif.force_compare;

  // commands only decoded while idle so acks and reports keep request order
  assign take = ICN_VALID_IN && ICN_READY_OUT && (state == ST_IDLE);
  assign is_read = take && !ICN_WRITE_IN;
  assign is_write = take && ICN_WRITE_IN;
  assign tif.start = is_read && (ICN_REG_IN == mmci_pkg::REG_SELF_TEST);

  // register number field selects the register read back
  always_comb begin
    read_word = mmci_pkg::UNMAPPED_READ;
    unique case (ICN_REG_IN)
      mmci_pkg::REG_DEVICE_TYPE: read_word = device_type;
      mmci_pkg::REG_DEVICE_ID: read_word = device_id;
      mmci_pkg::REG_STATE: begin
        read_word[mmci_pkg::STATE_WARM] = warm_start;
        read_word[mmci_pkg::STATE_DETACHED] = detached;
        read_word[mmci_pkg::STATE_BACKUP] = on_backup;
      end
      mmci_pkg::REG_ARRAY_LOW: read_word = array_low;
      mmci_pkg::REG_ARRAY_HIGH: read_word = array_high;
      mmci_pkg::REG_ARRAY_SIZE: read_word = {10'h000, array_size};
      default: read_word = mmci_pkg::UNMAPPED_READ;
    endcase
  end

  // command sequencer
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= ST_IDLE;
      pend_switch <= mmci_pkg::SW_NONE;
      pend_report <= mmci_pkg::RPT_NO_ERROR;
      pend_checker <= 1'b0;
      pend_both_lines <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // a self-test report must not inherit an earlier command's lines
          pend_switch <= mmci_pkg::SW_NONE;
          pend_checker <= 1'b0;
          pend_both_lines <= 1'b0;
          if (tif.start) begin
            state <= ST_TEST;
          end else if (is_write) begin
            unique case (ICN_REG_IN)
              mmci_pkg::REG_TEST_REPORT: begin
                pend_report <= mmci_pkg::RPT_TEST_REPORT;
                pend_checker <= ICN_DATA_IN[0];
                pend_both_lines <= 1'b1;
                state <= ST_REPORT;
              end
              mmci_pkg::REG_BUS_SWAP: begin
                // without a back-up bus the write is only acknowledged
                if (BACKUP_PRESENT_IN) begin
                  pend_switch <= mmci_pkg::SW_SWAP;
                  pend_report <= mmci_pkg::RPT_BUS_SWAP;
                  state <= ST_SWITCH;
                end
              end
              mmci_pkg::REG_BUS_DEACT: begin
                pend_switch <= mmci_pkg::SW_DETACH;
                pend_report <= mmci_pkg::RPT_DETACH;
                state <= ST_SWITCH;
              end
              mmci_pkg::REG_BUS_ACT: begin
                // only meaningful while running on a working back-up
                if (on_backup && detached) begin
                  pend_switch <= mmci_pkg::SW_ATTACH;
                  pend_report <= mmci_pkg::RPT_ATTACH;
                  state <= ST_SWITCH;
                end
              end
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_TEST: begin
          if (tif.done) begin
            pend_report <= tif.fail ? mmci_pkg::RPT_MODULE_ERROR
                                    : mmci_pkg::RPT_NO_ERROR;
            state <= ST_REPORT;
          end
        end
        ST_SWITCH: begin
          if (SWITCH_DONE_IN) begin
            state <= ST_REPORT;
          end
        end
        ST_REPORT: begin
          state <= ST_REPORT_WAIT;
        end
        ST_REPORT_WAIT: begin
          if (REPORT_DONE_IN) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ICN_READY_OUT <= 1'b0;
    end else begin
      // mirrors the idle state one cycle ahead of the next decode
      ICN_READY_OUT <= (state == ST_IDLE && !take) || (state == ST_REPORT_WAIT && REPORT_DONE_IN);
    end
  end
  // memory bus replies: acks before execution, self-test data after the read
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      REPLY_VALID_OUT <= 1'b0;
      REPLY_KIND_OUT <= mmci_pkg::REPLY_ACK;
      REPLY_DATA_OUT <= mmci_pkg::RESET_WORD;
      REPLY_PARITY_OUT <= 2'h0;
    end else begin
      REPLY_VALID_OUT <= 1'b0;
      if (is_write) begin
        REPLY_VALID_OUT <= 1'b1;
        REPLY_KIND_OUT <= mmci_pkg::REPLY_ACK;
        REPLY_DATA_OUT <= 16'hFFFF;
        REPLY_PARITY_OUT <= mmci_pkg::word_parity(16'hFFFF);
      end else if (is_read && !tif.start) begin
        REPLY_VALID_OUT <= 1'b1;
        REPLY_KIND_OUT <= mmci_pkg::REPLY_DATA;
        REPLY_DATA_OUT <= read_word;
        REPLY_PARITY_OUT <= mmci_pkg::word_parity(read_word);
      end else if (state == ST_TEST && tif.done) begin
        REPLY_VALID_OUT <= 1'b1;
        REPLY_KIND_OUT <= mmci_pkg::REPLY_DATA;
        REPLY_DATA_OUT <= tif.low_word;
        REPLY_PARITY_OUT <= mmci_pkg::word_parity(tif.low_word);
      end
    end
  end
  // error report issue
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      REPORT_VALID_OUT <= 1'b0;
      REPORT_CODE_OUT <= mmci_pkg::RPT_NO_ERROR;
      REPORT_MODULE_LINE_OUT <= 1'b0;
      REPORT_BUS_LINE_OUT <= 1'b0;
      REPORT_CHECKER_OUT <= 1'b0;
    end else begin
      REPORT_VALID_OUT <= (state == ST_REPORT);
      if (state == ST_REPORT) begin
        REPORT_CODE_OUT <= pend_report;
        REPORT_MODULE_LINE_OUT <= 1'b1;
        REPORT_BUS_LINE_OUT <= pend_both_lines || (pend_switch != mmci_pkg::SW_NONE);
        REPORT_CHECKER_OUT <= pend_checker;
      end
    end
  end
  // bus switch request and resulting bus state
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      SWITCH_REQ_OUT <= 1'b0;
      SWITCH_KIND_OUT <= mmci_pkg::SW_NONE;
      detached <= 1'b0;
      on_backup <= 1'b0;
    end else begin
      // written data never reaches here: only the write event matters
      SWITCH_REQ_OUT <= is_write && (ICN_REG_IN == mmci_pkg::REG_BUS_SWAP
        ? BACKUP_PRESENT_IN
        : ICN_REG_IN == mmci_pkg::REG_BUS_DEACT
          || (ICN_REG_IN == mmci_pkg::REG_BUS_ACT && on_backup && detached));
      if (is_write) begin
        SWITCH_KIND_OUT <= mmci_pkg::SW_NONE;
        if (ICN_REG_IN == mmci_pkg::REG_BUS_SWAP) begin
          SWITCH_KIND_OUT <= mmci_pkg::SW_SWAP;
        end else if (ICN_REG_IN == mmci_pkg::REG_BUS_DEACT) begin
          SWITCH_KIND_OUT <= mmci_pkg::SW_DETACH;
        end else if (ICN_REG_IN == mmci_pkg::REG_BUS_ACT) begin
          SWITCH_KIND_OUT <= mmci_pkg::SW_ATTACH;
        end
      end
      if (state == ST_SWITCH && SWITCH_DONE_IN) begin
        unique case (pend_switch)
          mmci_pkg::SW_SWAP: on_backup <= ~on_backup;
          mmci_pkg::SW_DETACH: begin
            detached <= 1'b1;
            on_backup <= BACKUP_PRESENT_IN;
          end
          mmci_pkg::SW_ATTACH: detached <= 1'b0;
          default: detached <= detached;
        endcase
      end
    end
  end
  assign BUS_DETACHED_OUT = detached;
  assign ON_BACKUP_OUT = on_backup;
  // memory requests refused while detached; register access is unaffected
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      MEM_ACCEPT_OUT <= 1'b0;
      MEM_REFUSE_OUT <= 1'b0;
    end else begin
      MEM_ACCEPT_OUT <= MEM_REQ_IN && !detached;
      MEM_REFUSE_OUT <= MEM_REQ_IN && detached;
    end
  end
  // incoming bus swap report clears the report counter field
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CLEAR_REPORT_COUNTER_OUT <= 1'b0;
    end else begin
      CLEAR_REPORT_COUNTER_OUT <= REPORT_RECEIVED_IN
        && (REPORT_RECEIVED_CODE_IN == mmci_pkg::RPT_BUS_SWAP);
    end
  end
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ARRAY_ADDR_OUT <= 20'h00000;
    end else if (tif.start) begin
      ARRAY_ADDR_OUT <= tif.addr;
    end
  end
  // power-up capture; parity on the memory-side word is trusted as valid
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      array_low <= mmci_pkg::RESET_WORD;
      array_high <= mmci_pkg::RESET_WORD;
    end else if (INIT_MEM_STROBE_IN) begin
      array_low <= MEMORY_BUS_DATA_IN;
    end else if (is_write && ICN_REG_IN == mmci_pkg::REG_ARRAY_LOW) begin
      array_low <= ICN_DATA_IN;
    end else if (is_write && ICN_REG_IN == mmci_pkg::REG_ARRAY_HIGH) begin
      array_high <= ICN_DATA_IN;
    end
  end
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      device_id <= mmci_pkg::RESET_WORD;
      warm_start <= 1'b0;
    end else if (INIT_PHASE1_STROBE_IN) begin
      // upper storage lines are reserved and dropped
      device_id <= mmci_pkg::RESET_WORD;
      device_id[mmci_pkg::ID_BUS_LSB +: 3] <=
        STORAGE_SIDE_LINES_IN[mmci_pkg::P1_BUS_LSB +: 3];
      device_id[mmci_pkg::ID_MODULE_LSB +: 6] <=
        STORAGE_SIDE_LINES_IN[mmci_pkg::P1_MODULE_LSB +: 6];
      device_id[mmci_pkg::ID_PARITY] <= STORAGE_SIDE_LINES_IN[mmci_pkg::P1_PARITY];
      warm_start <= STORAGE_SIDE_LINES_IN[mmci_pkg::P1_WARM];
    end
  end
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      device_type <= mmci_pkg::RESET_WORD;
      array_size <= 6'h00;
    end else if (INIT_PHASE2_STROBE_IN) begin
      array_size <= STORAGE_SIDE_LINES_IN[mmci_pkg::P2_SIZE_LSB +: 6];
      // bits 19..16 reserved, ignored
      device_type <= STORAGE_SIDE_LINES_IN[15:0];
      device_type[5:0] <= 6'h00;
    end
  end
endmodule // mmci_top

// ---- inc/mmci_pkg.sv ----
/*
  Constants, types and helpers shared by the maintenance command decoder,
  its detection self-test engine and the bench.
  Assumes a single 25 MHz component clock.
*/
package mmci_pkg;
  // register numbers of the interconnect address register field
  localparam logic [4:0] REG_DEVICE_TYPE = 5'h01;
  localparam logic [4:0] REG_DEVICE_ID = 5'h02;
  localparam logic [4:0] REG_STATE = 5'h06;
  localparam logic [4:0] REG_ARRAY_LOW = 5'h0B;
  localparam logic [4:0] REG_ARRAY_HIGH = 5'h0C;
  localparam logic [4:0] REG_ARRAY_SIZE = 5'h11;
  localparam logic [4:0] REG_SELF_TEST = 5'h1B;
  localparam logic [4:0] REG_TEST_REPORT = 5'h1C;
  localparam logic [4:0] REG_BUS_SWAP = 5'h1D;
  localparam logic [4:0] REG_BUS_DEACT = 5'h1E;
  localparam logic [4:0] REG_BUS_ACT = 5'h1F;

  // storage_phase_one field positions (storage_side_lines)
  localparam int P1_BUS_LSB = 0;
  localparam int P1_MODULE_LSB = 3;
  localparam int P1_PARITY = 9;
  localparam int P1_WARM = 10;
  // storage_phase_two field positions
  localparam int P2_SIZE_LSB = 0;
  localparam int P2_BOARD_LSB = 6;
  localparam int P2_PARTIAL_LSB = 8;
  localparam int P2_RAM_LSB = 10;
  localparam int P2_SPEED = 12;
  localparam int P2_BOUND = 13;
  localparam int P2_E = 14;
  localparam int P2_SPEED_READ = 15;

  // device ID register layout
  localparam int ID_BUS_LSB = 0;
  localparam int ID_MODULE_LSB = 3;
  localparam int ID_PARITY = 9;
  // state register layout
  localparam int STATE_WARM = 0;
  localparam int STATE_DETACHED = 1;
  localparam int STATE_BACKUP = 2;

  // reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // comparator groups exercised by the self-test
  localparam int COMPARE_GROUPS = 4;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int COMPARE_SETTLE_NS = 100;
  localparam int COMPARE_SETTLE_CYC = (COMPARE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RPT_NO_ERROR = 3'h0,
    RPT_MODULE_ERROR = 3'h1,
    RPT_TEST_REPORT = 3'h2,
    RPT_BUS_SWAP = 3'h3,
    RPT_DETACH = 3'h4,
    RPT_ATTACH = 3'h5
  } mmci_report_type;

  typedef enum logic [1:0] {
    SW_NONE = 2'h0,
    SW_SWAP = 2'h1,
    SW_DETACH = 2'h2,
    SW_ATTACH = 2'h3
  } mmci_switch_type;

  typedef enum logic {
    REPLY_ACK = 1'b0,
    REPLY_DATA = 1'b1
  } mmci_reply_type;

  function automatic logic [1:0] word_parity(input logic [15:0] w);
    return {^w[15:8], ^w[7:0]};
  endfunction
endpackage

// ---- inc/mmci_test_if.sv ----
/*
  Signals between the command decoder and the detection self-test engine.
  Assumes both ends share one clock.
*/
interface mmci_test_if;
  logic start;
  logic done;
  logic fail;
  logic [15:0] low_word;
  logic [19:0] addr;
  logic array_read;
  logic [31:0] array_data;
  logic array_valid;
  logic force_compare;
  logic [mmci_pkg::COMPARE_GROUPS-1:0] compare_flags;
  logic buffer_fail;

  modport engine(
    input start, addr, array_data, array_valid, compare_flags, buffer_fail,
    output done, fail, low_word, array_read, force_compare
  );
  modport ctrl(
    output start, addr, array_data, array_valid, compare_flags, buffer_fail,
    input done, fail, low_word, array_read, force_compare
  );
endinterface

// ---- testbench/mmci_assertions.sv ----
/*
  port assertions for mmci_top.
  assumes one clock domain, bound to every mmci_top instance.
*/
module mmci_assertions (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic ICN_VALID_IN,
  input wire logic ICN_WRITE_IN,
  input wire logic [4:0] ICN_REG_IN,
  input wire logic [15:0] ICN_DATA_IN,
  input wire logic ICN_READY_OUT,
  input wire logic REPLY_VALID_OUT,
  input wire mmci_pkg::mmci_reply_type REPLY_KIND_OUT,
  input wire logic [15:0] REPLY_DATA_OUT,
  input wire logic [1:0] REPLY_PARITY_OUT,
  input wire logic REPORT_VALID_OUT,
  input wire mmci_pkg::mmci_report_type REPORT_CODE_OUT,
  input wire logic REPORT_MODULE_LINE_OUT,
  input wire logic REPORT_BUS_LINE_OUT,
  input wire logic REPORT_CHECKER_OUT,
  input wire logic REPORT_RECEIVED_IN,
  input wire mmci_pkg::mmci_report_type REPORT_RECEIVED_CODE_IN,
  input wire logic CLEAR_REPORT_COUNTER_OUT,
  input wire logic SWITCH_REQ_OUT,
  input wire mmci_pkg::mmci_switch_type SWITCH_KIND_OUT,
  input wire logic MEM_REQ_IN,
  input wire logic MEM_REFUSE_OUT,
  input wire logic BUS_DETACHED_OUT,
  input wire logic FORCE_COMPARE_OUT
);
  logic pick;
  wire take = ICN_VALID_IN && ICN_READY_OUT;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // reporter choice taken with the write
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN)
      pick <= 1'b0;
    else if (take && ICN_WRITE_IN && ICN_REG_IN == mmci_pkg::REG_TEST_REPORT)
      pick <= ICN_DATA_IN[0];
  end
  sequence s_wr(logic [4:0] r);
    take && ICN_WRITE_IN && ICN_REG_IN == r;
  endsequence
  sequence s_ack;
    REPLY_VALID_OUT && REPLY_KIND_OUT == mmci_pkg::REPLY_ACK && REPLY_DATA_OUT == 16'hFFFF;
  endsequence
  a_write_ack: assert property (take && ICN_WRITE_IN |=> s_ack)
    else $error("write not acknowledged");
  a_ack_first: assert property (s_wr(mmci_pkg::REG_TEST_REPORT) |=>
    !REPORT_VALID_OUT ##[1:40] REPORT_VALID_OUT) else $error("test report order");
  a_test_lines: assert property (REPORT_VALID_OUT && REPORT_CODE_OUT ==
    mmci_pkg::RPT_TEST_REPORT |-> REPORT_MODULE_LINE_OUT && REPORT_BUS_LINE_OUT
    && REPORT_CHECKER_OUT == pick) else $error("test report lines wrong");
  a_force_three: assert property (take && !ICN_WRITE_IN &&
    ICN_REG_IN == mmci_pkg::REG_SELF_TEST |=> FORCE_COMPARE_OUT [*3] ##1 !FORCE_COMPARE_OUT)
    else $error("compare force length");
  a_reply_parity: assert property (REPLY_VALID_OUT |->
    REPLY_PARITY_OUT == {^REPLY_DATA_OUT[15:8], ^REPLY_DATA_OUT[7:0]}) else $error("parity");
  a_detach_req: assert property (s_wr(mmci_pkg::REG_BUS_DEACT) |=>
    SWITCH_REQ_OUT && SWITCH_KIND_OUT == mmci_pkg::SW_DETACH) else $error("no detach");
  a_clear_count: assert property (REPORT_RECEIVED_IN &&
    REPORT_RECEIVED_CODE_IN == mmci_pkg::RPT_BUS_SWAP |=> CLEAR_REPORT_COUNTER_OUT)
    else $error("counter not cleared");
  a_mem_refuse: assert property (MEM_REQ_IN && BUS_DETACHED_OUT |=> MEM_REFUSE_OUT)
    else $error("detached bus served memory");
  a_one_cmd: assert property (REPORT_VALID_OUT |-> !ICN_READY_OUT)
    else $error("ready during report");
endmodule // mmci_assertions
bind mmci_top mmci_assertions u_mmci_assertions (.*);

// ---- testbench/mmci_far_model.sv ----
/*
  far-side model: report lines, bus switch logic and storage array.
  assumes single-cycle request pulses from mmci_top on one clock.
*/
module mmci_far_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic switch_req_in,
  input wire logic report_valid_in,
  input wire logic array_read_in,
  input wire logic [31:0] word_in,
  output logic switch_done_out,
  output logic report_done_out,
  output logic array_valid_out,
  output logic [31:0] array_data_out
);
  logic [5:0] sw, rp, ar;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sw <= 6'h00;
      rp <= 6'h00;
      ar <= 6'h00;
    end else begin
      sw <= {sw[4:0], switch_req_in};
      rp <= {rp[4:0], report_valid_in};
      ar <= {ar[4:0], array_read_in};
    end
  end
  // slow answers come five cycles later
  assign switch_done_out = sw[slow_in ? 5 : 0];
  assign report_done_out = rp[slow_in ? 5 : 0];
  assign array_valid_out = ar[slow_in ? 5 : 0];
  // data bus not held outside the valid cycle
  assign array_data_out = array_valid_out ? word_in : ~word_in;
endmodule // mmci_far_model

// ---- testbench/tb_mmci_top.sv ----
/*
  testbench of mmci_top: init capture, self-test and maintenance commands.
  assumes mmci_far_model answers switch, report and array requests.
*/
module tb_mmci_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, iv, iw, rdy, rv, rpv, ml, bl, ck, rdn, rrx, clr, sreq, sdn, bk, mreq;
  logic macc, mref, ard, aval, lockstep_compare, bfail, im, i1, i2, det, onb, slow;
  logic [4:0] ireg;
  logic [15:0] idata, rdata, mdata, hi;
  logic [1:0] rpar;
  logic [19:0] sl, p1, p2, aaddr;
  logic [31:0] adata, word;
  logic [3:0] stuck;
  logic [2:0] cq[$];
  logic [15:0] rq[$];
  mmci_pkg::mmci_reply_type rk;
  mmci_pkg::mmci_report_type rc, rxc;
  mmci_pkg::mmci_switch_type sk;
  int err_total, cmp_count;
  mmci_top u_mmci_top (.CLK_IN(clk), .RST_IN(rst), .ICN_VALID_IN(iv), .ICN_WRITE_IN(iw),
    .ICN_REG_IN(ireg), .ICN_DATA_IN(idata), .ICN_READY_OUT(rdy), .REPLY_VALID_OUT(rv),
    .REPLY_KIND_OUT(rk), .REPLY_DATA_OUT(rdata), .REPLY_PARITY_OUT(rpar),
    .REPORT_VALID_OUT(rpv), .REPORT_CODE_OUT(rc), .REPORT_MODULE_LINE_OUT(ml),
    .REPORT_BUS_LINE_OUT(bl), .REPORT_CHECKER_OUT(ck), .REPORT_DONE_IN(rdn),
    .REPORT_RECEIVED_IN(rrx), .REPORT_RECEIVED_CODE_IN(rxc), .CLEAR_REPORT_COUNTER_OUT(clr),
    .SWITCH_REQ_OUT(sreq), .SWITCH_KIND_OUT(sk), .SWITCH_DONE_IN(sdn),
    .BACKUP_PRESENT_IN(bk), .MEM_REQ_IN(mreq), .MEM_ACCEPT_OUT(macc), .MEM_REFUSE_OUT(mref),
    .ARRAY_READ_OUT(ard), .ARRAY_ADDR_OUT(aaddr), .ARRAY_DATA_IN(adata),
    .ARRAY_VALID_IN(aval), .FORCE_COMPARE_OUT(lockstep_compare), .COMPARE_FLAGS_IN(lockstep_compare ? ~stuck : 4'h0),
    .BUFFER_CHECK_FAIL_IN(bfail), .INIT_MEM_STROBE_IN(im), .INIT_PHASE1_STROBE_IN(i1),
    .INIT_PHASE2_STROBE_IN(i2), .MEMORY_BUS_DATA_IN(mdata), .STORAGE_SIDE_LINES_IN(sl),
    .BUS_DETACHED_OUT(det), .ON_BACKUP_OUT(onb));
  mmci_far_model u_mmci_far_model (.clk_in(clk), .rst_in(rst), .slow_in(slow),
    .switch_req_in(sreq), .report_valid_in(rpv), .array_read_in(ard), .word_in(word),
    .switch_done_out(sdn), .report_done_out(rdn), .array_valid_out(aval),
    .array_data_out(adata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy;
    for (int n = 0; n < 300 && rdy !== 1'b1; n++) @(negedge clk);
    if (rdy !== 1'b1) chk(16'h0000, 16'h0001);
  endtask
  // one request strobe, expected reply noted first
  task automatic icn(input logic w, input logic [4:0] r, input logic [15:0] d, e);
    wait_rdy;
    rq.push_back(e);
    {iw, ireg, idata, iv} = {w, r, d, 1'b1};
    @(negedge clk);
    iv = 1'b0;
  endtask
  // c[3] set means no report expected
  task automatic cmd(input logic [4:0] r, input logic b, input logic [3:0] c,
      input logic [1:0] st, input logic ko);
    bk = b;
    if (!c[3]) cq.push_back(c[2:0]);
    icn(1'b1, r, 16'($urandom), 16'hFFFF);
    wait_rdy;
    chk({15'h0, det}, {15'h0, st[1]});
    if (ko) chk({15'h0, onb}, {15'h0, st[0]});
  endtask
  always @(negedge clk) begin
    if (rv) begin
      if (rq.size() == 0) rq.push_back(~rdata);
      chk(rdata, rq.pop_front());
    end
    if (rpv) begin
      if (cq.size() == 0) cq.push_back(~rc);
      chk({13'h0, rc}, {13'h0, cq.pop_front()});
    end
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    final_report;
  end
  initial begin
    {iv, iw, rrx, bk, mreq, im, i1, i2, bfail, slow} = '0;
    {ireg, idata, mdata, sl, stuck, word} = '0;
    rxc = mmci_pkg::RPT_NO_ERROR;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    void'($urandom(32'he910));
    // parity pins are not modelled on this port set
    mdata = 16'($urandom);
    p1 = 20'($urandom);
    p2 = 20'($urandom);
    {im, sl} = {1'b1, p1};
    @(negedge clk);
    {im, i1} = 2'b01;
    @(negedge clk);
    {i1, i2, sl} = {2'b01, p2};
    @(negedge clk);
    i2 = 1'b0;
    icn(1'b0, mmci_pkg::REG_ARRAY_LOW, 16'h0000, mdata);
    icn(1'b0, mmci_pkg::REG_DEVICE_ID, 16'h0000, {6'h00, p1[9:0]});
    icn(1'b0, mmci_pkg::REG_STATE, 16'h0000, {15'h0000, p1[10]});
    icn(1'b0, mmci_pkg::REG_ARRAY_SIZE, 16'h0000, {10'h000, p2[5:0]});
    icn(1'b0, mmci_pkg::REG_DEVICE_TYPE, 16'h0000, {p2[15:6], 6'h00});
    icn(1'b0, 5'h1A, 16'h0000, mmci_pkg::UNMAPPED_READ);
    hi = 16'($urandom);
    icn(1'b1, mmci_pkg::REG_ARRAY_HIGH, hi, 16'hFFFF);
    $display("init capture test done");
    for (int t = 0; t < 3; t++) begin
      word = $urandom;
      stuck = (t == 1) ? 4'h1 << ($urandom % 4) : 4'h0;
      {bfail, slow} = {t == 2, t == 1};
      cq.push_back(t ? mmci_pkg::RPT_MODULE_ERROR : mmci_pkg::RPT_NO_ERROR);
      icn(1'b0, mmci_pkg::REG_SELF_TEST, 16'($urandom), word[15:0]);
      wait_rdy;
    end
    chk(aaddr[15:0], mdata);
    chk(16'(aaddr[19:16]), 16'(hi[3:0]));
    {bfail, slow} = 2'b00;
    for (int b = 0; b < 2; b++) begin
      cq.push_back(mmci_pkg::RPT_TEST_REPORT);
      icn(1'b1, mmci_pkg::REG_TEST_REPORT, 16'($urandom) & 16'hFFFE | 16'(b), 16'hFFFF);
    end
    $display("self-test and test report done");
    cmd(mmci_pkg::REG_BUS_SWAP, 1'b0, 4'h8, 2'b00, 1'b1);
    cmd(mmci_pkg::REG_BUS_SWAP, 1'b1, {1'b0, mmci_pkg::RPT_BUS_SWAP}, 2'b01, 1'b1);
    cmd(mmci_pkg::REG_BUS_SWAP, 1'b1, {1'b0, mmci_pkg::RPT_BUS_SWAP}, 2'b00, 1'b1);
    cmd(mmci_pkg::REG_BUS_DEACT, 1'b1, {1'b0, mmci_pkg::RPT_DETACH}, 2'b11, 1'b1);
    mreq = 1'b1;
    @(negedge clk);
    mreq = 1'b0;
    chk({14'h0, macc, mref}, 16'h0001);
    icn(1'b0, mmci_pkg::REG_ARRAY_LOW, 16'h0000, mdata);
    cmd(mmci_pkg::REG_BUS_ACT, 1'b1, {1'b0, mmci_pkg::RPT_ATTACH}, 2'b00, 1'b0);
    cmd(mmci_pkg::REG_BUS_ACT, 1'b1, 4'h8, 2'b00, 1'b0);
    mreq = 1'b1;
    @(negedge clk);
    mreq = 1'b0;
    chk({14'h0, macc, mref}, 16'h0002);
    $display("bus command test done");
    for (int k = 0; k < 6; k++) begin
      rrx = 1'b1;
      rxc = mmci_pkg::mmci_report_type'(k);
      @(negedge clk);
      rrx = 1'b0;
      chk({15'h0, clr}, {15'h0, k == 3});
    end
    repeat (20) @(negedge clk);
    chk(16'(rq.size() + cq.size()), 16'h0000);
    $display("report counter test done");
    final_report;
  end
endmodule // tb_mmci_top
